// [design/tpo_pwm.v]
`timescale 1ns/10ps
`include "tpo_defs.vh"
module tpo_pwm (
  input wire clk_i,
  input wire rst_i,
  input wire sleep_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg pwm_output_pin_o,
  output reg pwm_output_pin_oe_n_o,
  output reg period_match_o
);
  ////////////////////////////////////////////////////////////////
  reg [7:0] unit_control_register;
  reg [7:0] duty_staging_register;
  reg [7:0] duty_active_register;
  reg [1:0] duty_low_latch;
  reg [7:0] period_register;
  reg [7:0] timer_control_register;
  reg [1:0] pin_reg;
  reg period_match_flag;
  reg update_flag;
  reg pwm_latch;
  reg pwm_armed;
  wire [7:0] period_timer;
  wire [1:0] ext_bits;
  wire t_inc;
  wire t_match;
  wire t_update;
  wire pwm_mode;
  wire wr;
  wire rd;
  wire run;
  wire [9:0] duty_value;
  wire clr_timer;
  assign pwm_mode = unit_control_register[3:2] == `TPO_MODE_PWM;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign run = timer_control_register[`TPO_TC_ON] && !sleep_i;
  assign clr_timer = wr && wb_adr_i == `TPO_ADR_TIMER;
  assign duty_value = {duty_active_register, duty_low_latch};

  ////////////////////////////////////////////////////////////////
  tpo_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .ps_sel_i(timer_control_register[`TPO_TC_PS_HI:`TPO_TC_PS_LO]),
    .period_i(period_register),
    .post_i(timer_control_register[`TPO_TC_POST_HI:`TPO_TC_POST_LO]),
    .clr_i(clr_timer),
    .count_o(period_timer),
    .ext_o(ext_bits),
    .inc_o(t_inc),
    .match_o(t_match),
    .update_o(t_update)
  );

  ////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_control_register <= 8'h00;
      duty_staging_register <= 8'h00;
      period_register <= `TPO_RST_PERIOD;
      timer_control_register <= 8'h00;
      pin_reg <= `TPO_RST_PIN;
    end else if (wr) begin
      case (wb_adr_i)
        `TPO_ADR_CTRL: unit_control_register <= {2'b00, wb_dat_i[5:0]};
        `TPO_ADR_STAGE: duty_staging_register <= wb_dat_i[7:0];
        `TPO_ADR_PERIOD: period_register <= wb_dat_i[7:0];
        `TPO_ADR_TCTRL: timer_control_register <= {1'b0, wb_dat_i[6:0]};
        `TPO_ADR_PIN: pin_reg <= wb_dat_i[1:0];
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // active duty, output latch and flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      duty_active_register <= 8'h00;
      duty_low_latch <= 2'd0;
      pwm_latch <= 1'b0;
      pwm_armed <= 1'b0;
      period_match_flag <= 1'b0;
      update_flag <= 1'b0;
    end else begin
      if (t_match) begin
        period_match_flag <= 1'b1;
      end else if (wr && wb_adr_i == `TPO_ADR_STATUS && wb_dat_i[`TPO_ST_MATCH]) begin
        period_match_flag <= 1'b0;
      end
      if (t_update) begin
        update_flag <= 1'b1;
      end else if (wr && wb_adr_i == `TPO_ADR_STATUS && wb_dat_i[`TPO_ST_UPDATE]) begin
        update_flag <= 1'b0;
      end
      if (wr && wb_adr_i == `TPO_ADR_CTRL &&
          (wb_dat_i[7:0] == 8'h00 || wb_dat_i[3:2] != unit_control_register[3:2])) begin
        pwm_latch <= 1'b0;
        pwm_armed <= 1'b0;
      end else if (!pwm_mode) begin
        pwm_latch <= 1'b0;
        pwm_armed <= 1'b0;
        if (wr && wb_adr_i == `TPO_ADR_ACTIVE) begin
          duty_active_register <= wb_dat_i[7:0];
        end
      end else if (t_match) begin
        duty_active_register <= duty_staging_register;
        duty_low_latch <= unit_control_register[5:4];
        pwm_armed <= 1'b1;
        pwm_latch <= {duty_staging_register, unit_control_register[5:4]} != 10'h000;
      end else if (pwm_armed && pwm_latch &&
                   duty_value == {period_timer, ext_bits}) begin
        pwm_latch <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin and bus outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwm_output_pin_o <= 1'b0;
      pwm_output_pin_oe_n_o <= 1'b1;
      period_match_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      pwm_output_pin_oe_n_o <= pin_reg[`TPO_PIN_DIR];
      pwm_output_pin_o <= pwm_mode ? pwm_latch : pin_reg[`TPO_PIN_DATA];
      period_match_o <= period_match_flag;
      wb_ack_o <= rd;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        case (wb_adr_i)
          `TPO_ADR_CTRL: wb_dat_o[7:0] <= unit_control_register;
          `TPO_ADR_STAGE: wb_dat_o[7:0] <= duty_staging_register;
          `TPO_ADR_ACTIVE: wb_dat_o[7:0] <= duty_active_register;
          `TPO_ADR_PERIOD: wb_dat_o[7:0] <= period_register;
          `TPO_ADR_TCTRL: wb_dat_o[7:0] <= timer_control_register;
          `TPO_ADR_TIMER: wb_dat_o[7:0] <= period_timer;
          `TPO_ADR_PIN: wb_dat_o[1:0] <= pin_reg;
          `TPO_ADR_STATUS: wb_dat_o[2:0] <= {pwm_latch, update_flag, period_match_flag};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// [design/tpo_timer.v]
`timescale 1ns/10ps
`include "tpo_defs.vh"
module tpo_timer (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [1:0] ps_sel_i,
  input wire [7:0] period_i,
  input wire [3:0] post_i,
  input wire clr_i,
  output reg [7:0] count_o,
  output reg [1:0] ext_o,
  output reg inc_o,
  output reg match_o,
  output reg update_o
);
  reg [1:0] qph;
  reg [3:0] pre;
  reg [3:0] post_cnt;
  wire q_end;
  wire pre_end;
  wire [3:0] pre_nxt;
  assign q_end = (qph == 2'd3);
  assign pre_nxt = pre + 4'h1;
  // prescale 1, 4 or 16 instruction cycles of four clocks each
  assign pre_end = q_end && (ps_sel_i == 2'b00 ? 1'b1 :
                   ps_sel_i == 2'b01 ? (pre[1:0] == 2'd3) : (pre == 4'hf));
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      qph <= 2'd0;
      pre <= 4'h0;
      count_o <= 8'h00;
      ext_o <= 2'd0;
      inc_o <= 1'b0;
      match_o <= 1'b0;
      update_o <= 1'b0;
      post_cnt <= 4'h0;
    end else begin
      inc_o <= 1'b0;
      match_o <= 1'b0;
      update_o <= 1'b0;
      if (run_i) begin
        qph <= qph + 2'd1;
        if (q_end) begin
          pre <= pre_end ? 4'h0 : pre + 4'h1;
        end
        if (pre_end) begin
          inc_o <= 1'b1;
          if (count_o == period_i) begin
            count_o <= 8'h00;
            match_o <= 1'b1;
            post_cnt <= (post_cnt == post_i) ? 4'h0 : post_cnt + 4'h1;
            update_o <= (post_cnt == post_i);
          end else begin
            count_o <= count_o + 8'h01;
          end
        end
        // extension bits: quarter phase or prescaler top bits
        case (ps_sel_i)
          2'b00: ext_o <= qph + 2'd1;
          2'b01: ext_o <= q_end ? pre[1:0] + 2'd1 : pre[1:0];
          default: ext_o <= q_end ? pre_nxt[3:2] : pre[3:2];
        endcase
      end
    end
  end
endmodule

// [include/tpo_defs.vh]
`ifndef TPO_DEFS_VH
`define TPO_DEFS_VH
// register byte offsets
`define TPO_ADR_CTRL 8'h00
`define TPO_ADR_STAGE 8'h04
`define TPO_ADR_ACTIVE 8'h08
`define TPO_ADR_PERIOD 8'h0c
`define TPO_ADR_TCTRL 8'h10
`define TPO_ADR_TIMER 8'h14
`define TPO_ADR_PIN 8'h18
`define TPO_ADR_STATUS 8'h1c
// control register fields
`define TPO_CTRL_DLO_HI 5
`define TPO_CTRL_DLO_LO 4
`define TPO_MODE_HI 3
`define TPO_MODE_LO 0
`define TPO_MODE_OFF 4'h0
`define TPO_MODE_PWM 2'h3
// timer control fields
`define TPO_TC_PS_HI 1
`define TPO_TC_PS_LO 0
`define TPO_TC_ON 2
`define TPO_TC_POST_HI 6
`define TPO_TC_POST_LO 3
// pin register fields
`define TPO_PIN_DIR 0
`define TPO_PIN_DATA 1
// status register fields
`define TPO_ST_MATCH 0
`define TPO_ST_UPDATE 1
`define TPO_ST_LEVEL 2
// reset values
`define TPO_RST_PERIOD 8'hff
`define TPO_RST_PIN 2'h1
// oscillator periods per instruction cycle
`define TPO_QPHASES 4
`endif

// [tb/test_timer_based_pwm_output.sv]
`timescale 1ns/10ps
`include "tpo_defs.vh"
module test_timer_based_pwm_output;
  logic clk_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic [3:0] wb_sel_i = 4'hf;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, pwm_output_pin_o, pwm_output_pin_oe_n_o, period_match_o;
  int error_cnt = 0, checks = 0, tick = 0, hi, lo, p, d, s, f;
  tpo_pwm dut (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_output_pin_o(pwm_output_pin_o), .pwm_output_pin_oe_n_o(pwm_output_pin_oe_n_o),
    .period_match_o(period_match_o));
  initial forever #4 clk_i = ~clk_i;
  //////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h0, v};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // high and low cycle counts of one full period
  task meas;
    hi = 0;
    lo = 0;
    @(posedge pwm_output_pin_o);
    while (pwm_output_pin_o === 1'b1) begin
      @(posedge clk_i);
      #1 hi++;
    end
    while (pwm_output_pin_o === 1'b0) begin
      @(posedge clk_i);
      #1 lo++;
    end
  endtask
  task cfg(input logic [1:0] sel);
    wb(`TPO_ADR_CTRL, 1'b1, 8'h00);
    wb(`TPO_ADR_PERIOD, 1'b1, p[7:0]);
    wb(`TPO_ADR_STAGE, 1'b1, d[9:2]);
    wb(`TPO_ADR_PIN, 1'b1, 8'h00);
    wb(`TPO_ADR_TCTRL, 1'b1, {1'b0, 4'($urandom), 1'b1, sel});
    wb(`TPO_ADR_TIMER, 1'b1, 8'h00);
    wb(`TPO_ADR_CTRL, 1'b1, {2'b00, d[1:0], `TPO_MODE_PWM, sel});
  endtask
  function int per_exp(int pr, int ps);
    return (pr + 1) * 4 * ps;
  endfunction
  function int fac(int sel);
    return sel == 0 ? 1 : (sel == 1 ? 4 : 16);
  endfunction
  //////////////////////////////////////////////////
  initial begin
    void'($urandom(37));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`TPO_ADR_PERIOD, 1'b0, 8'h00);
    chk(q, {24'h0, `TPO_RST_PERIOD});
    // write without lane 0 is refused
    wb_sel_i <= 4'he;
    wb(`TPO_ADR_PERIOD, 1'b1, 8'h42);
    wb_sel_i <= 4'hf;
    wb(`TPO_ADR_PERIOD, 1'b0, 8'h00);
    chk(q, {24'h0, `TPO_RST_PERIOD});
    wb(`TPO_ADR_PIN, 1'b0, 8'h00);
    chk(q, {30'h0, `TPO_RST_PIN});
    wb(8'h20, 1'b0, 8'h00);
    chk(q, 32'h0);
    for (int sel = 0; sel < 4; sel++) begin
      f = fac(sel);
      p = 2 + $urandom % 6;
      d = 1 + $urandom % (4 * p + 3);
      cfg(sel[1:0]);
      chk(pwm_output_pin_oe_n_o, 1'b0);
      meas;
      chk(hi, d * f);
      chk(hi + lo, per_exp(p, f));
      s = 1 + $urandom % p;
      wb(`TPO_ADR_STAGE, 1'b1, s[7:0]);
      wb(`TPO_ADR_ACTIVE, 1'b1, 8'h5a);
      wb(`TPO_ADR_ACTIVE, 1'b0, 8'h00);
      chk(q, {24'h0, d[9:2]});
      @(posedge clk_i) sleep_i <= 1'b1;
      wb(`TPO_ADR_STATUS, 1'b0, 8'h00);
      chk(q[0], 1'b1);
      chk(period_match_o, 1'b1);
      wb(`TPO_ADR_TIMER, 1'b0, 8'h00);
      lo = q;
      wb(`TPO_ADR_STATUS, 1'b1, 8'h01);
      repeat (20) @(posedge clk_i);
      wb(`TPO_ADR_STATUS, 1'b0, 8'h00);
      chk(q[0], 1'b0);
      chk(period_match_o, 1'b0);
      wb(`TPO_ADR_TIMER, 1'b0, 8'h00);
      chk(q, lo);
      sleep_i <= 1'b0;
      meas;
      chk(hi, (4 * s + d % 4) * f);
      chk(hi + lo, per_exp(p, f));
    end
    p = 3;
    for (int k = 0; k < 2; k++) begin
      d = k ? 16 + $urandom % 1000 : 0;
      cfg(2'b00);
      repeat (40) @(posedge clk_i);
      hi = 0;
      repeat (16) begin
        @(posedge clk_i);
        hi += (pwm_output_pin_o === 1'b1);
      end
      chk(hi, k ? 16 : 0);
    end
    wb(`TPO_ADR_CTRL, 1'b1, 8'h00);
    wb(`TPO_ADR_STATUS, 1'b0, 8'h00);
    chk(q[2], 1'b0);
    chk(pwm_output_pin_o, 1'b0);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    wb(`TPO_ADR_CTRL, 1'b0, 8'h00);
    chk(q, 32'h0);
    chk(pwm_output_pin_oe_n_o, 1'b1);
    stop_test;
  end
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick == 30000) begin
      error_cnt++;
      stop_test;
    end
  end
endmodule

// [tb/tpo_pwm_sva.sv]
`timescale 1ns/10ps
`include "tpo_defs.vh"
module tpo_pwm_chk (
  input wire clk_i,
  input wire rst_i,
  input wire sleep_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pwm_output_pin_o,
  input wire pwm_output_pin_oe_n_o,
  input wire period_match_o
);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = take && wb_we_i && wb_sel_i[0];
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UNMAPPED: assert property (take && !wb_we_i && wb_adr_i > 8'h1f |=> wb_dat_o == 32'h0)
    else $error("unmapped read");
  AST_RST_OFF: assert property ($fell(rst_i) |-> !pwm_output_pin_o && pwm_output_pin_oe_n_o)
    else $error("reset state");
  AST_DIR_OUT: assert property (wr && wb_adr_i == `TPO_ADR_PIN && !wb_dat_i[0]
    |=> ##1 !pwm_output_pin_oe_n_o) else $error("pin not driven");
  AST_DIR_HOLD: assert property ($changed(pwm_output_pin_oe_n_o) && !$past(rst_i)
    |-> wb_ack_o || $past(wb_ack_o)) else $error("direction moved");
  AST_FLAG_CLR: assert property ($fell(period_match_o) && !$past(rst_i)
    |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("flag lost");
  AST_SLEEP: assert property ($past(sleep_i) && $past(sleep_i, 2) && $past(sleep_i, 3)
    && !$past(rst_i) && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |-> $stable(pwm_output_pin_o))
    else $error("pin moved in sleep");
  cover property (wr && wb_adr_i == `TPO_ADR_CTRL);
  cover property ($rose(period_match_o));
  cover property ($fell(pwm_output_pin_o) && !pwm_output_pin_oe_n_o);
endmodule
//////////////////////////////////////////////////
bind tpo_pwm tpo_pwm_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pwm_output_pin_o(pwm_output_pin_o), .pwm_output_pin_oe_n_o(pwm_output_pin_oe_n_o),
  .period_match_o(period_match_o));
